// file: verilog/bbsd_defs.vh
/*
 constants for the branch and bit-set decoder: opcode fields, quarter
 phases, address map. assumes a 16-bit instruction word per fetch.
*/
`ifndef BBSD_DEFS_VH
`define BBSD_DEFS_VH
// ==========================================================
// opcode prefixes
`define BBSD_OP_BNOVF      8'he5
`define BBSD_OP_BNZF       8'he1
`define BBSD_OP_BRAF       5'h1a
`define BBSD_OP_BSETF      4'h8
// ==========================================================
// quarter phases of one instruction cycle
`define BBSD_Q1            2'h0
`define BBSD_Q2            2'h1
`define BBSD_Q3            2'h2
`define BBSD_Q4            2'h3
// ==========================================================
// address map
`define BBSD_PC_W          21
`define BBSD_PC_RST        21'h000000
`define BBSD_PC_STEP       21'h000002
`define BBSD_ADDR_W        12
`define BBSD_ACC_LIMIT     8'h5f
`define BBSD_ACC_HI_BANK   4'hf
`define BBSD_ACC_LO_BANK   4'h0
`endif

// file: verilog/bbsd_decoder.v
/*
 branch and bit-set decoder: executes the overflow-clear and zero-clear
 branches, the unconditional relative jump and the register bit set.
 assumes instruction, flags, bank and index base come from the same
 clock domain; other opcodes are executed elsewhere and pass as no-ops.
 limitation: flags are read once, in the last quarter, so a producer
 that finishes in that same quarter is seen one instruction late.
 a taken jump costs one empty slot; no fetch is made in it.
*/
`timescale 1ns/1ps
`include "bbsd_defs.vh"
module bbsd_decoder (
  // clock and reset
  input  wire                    sys_clk_in,
  input  wire                    rst_in,
  // program fetch
  input  wire [15:0]             instr_word_in,
  output wire [`BBSD_PC_W-1:0]   program_counter_out,
  // status flags and addressing state
  input  wire                    overflow_flag_in,
  input  wire                    zero_flag_in,
  input  wire [3:0]              bank_select_register_in,
  input  wire                    ext_set_enable_in,
  input  wire [11:0]             index_base_in,
  // data memory
  output wire [`BBSD_ADDR_W-1:0] mem_addr_out,
  output wire                    mem_rd_out,
  input  wire [7:0]              mem_rdata_in,
  output wire                    mem_wr_out,
  output wire [7:0]              mem_wdata_out,
  // status
  output wire                    status_we_out,
  output wire [1:0]              quarter_out,
  output wire                    branch_taken_out
);
  // ==========================================================
  // decode helpers
  function [`BBSD_ADDR_W-1:0] bbsd_reg_addr;
    input [15:0] iw;
    input [3:0]  bank;
    input        ext_en;
    input [11:0] base;
    begin
      // access bank: low part below 0x60, the rest maps to the top bank
      if (iw[8]) begin
        bbsd_reg_addr = {bank, iw[7:0]};
      end else if (ext_en && (iw[7:0] <= `BBSD_ACC_LIMIT)) begin
        bbsd_reg_addr = base + {4'h0, iw[7:0]};
      end else if (iw[7:0] <= `BBSD_ACC_LIMIT) begin
        bbsd_reg_addr = {`BBSD_ACC_LO_BANK, iw[7:0]};
      end else begin
        bbsd_reg_addr = {`BBSD_ACC_HI_BANK, iw[7:0]};
      end
    end
  endfunction

  function bbsd_is_bset;
    input [15:0] iw;
    begin
      bbsd_is_bset = (iw[15:12] == `BBSD_OP_BSETF);
    end
  endfunction

  // sign-extend a word offset and double it into a byte offset
  function [`BBSD_PC_W-1:0] bbsd_rel_offset;
    input [15:0] iw;
    input        wide;
    begin
      if (wide) begin
        bbsd_rel_offset = {{9{iw[10]}}, iw[10:0], 1'b0};
      end else begin
        bbsd_rel_offset = {{12{iw[7]}}, iw[7:0], 1'b0};
      end
    end
  endfunction

  // ==========================================================
  // state
  // valid_ff low marks the empty slot after a taken jump
  reg  [1:0]              phase_ff;
  reg  [`BBSD_PC_W-1:0]   pc_ff;
  reg  [15:0]             ir_ff;
  reg                     valid_ff;
  reg                     flush_ff;
  reg  [`BBSD_ADDR_W-1:0] addr_ff;
  reg  [7:0]              wdata_ff;
  reg                     taken_ff;

  wire is_jump_if_no_overflow = (ir_ff[15:8] == `BBSD_OP_BNOVF);
  wire is_bnz  = (ir_ff[15:8] == `BBSD_OP_BNZF);
  wire is_bra  = (ir_ff[15:11] == `BBSD_OP_BRAF);
  wire is_bset = bbsd_is_bset(ir_ff);

  // flags are read only, never driven back
  // flags sampled at Q4, so a producer finishing in Q4 is seen next cycle
  wire take = valid_ff &&
              ((is_jump_if_no_overflow && !overflow_flag_in) ||
               (is_bnz && !zero_flag_in) ||
               is_bra);

  // pc_ff already holds instruction address plus 2
  wire [`BBSD_PC_W-1:0] target = pc_ff + bbsd_rel_offset(ir_ff, is_bra);

  // ==========================================================
  // bit-set merge: one lane per bit of the byte
  wire [7:0] merged;
  genvar     gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_merge
      // a lane is forced high only when it is the selected bit
      assign merged[gi] = mem_rdata_in[gi] | (ir_ff[11:9] == gi);
    end
  endgenerate

  // ==========================================================
  // next state
  reg  [1:0]              nxt_phase;
  reg  [`BBSD_PC_W-1:0]   nxt_pc;
  reg  [15:0]             nxt_ir;
  reg                     nxt_valid;
  reg                     nxt_flush;
  reg  [`BBSD_ADDR_W-1:0] nxt_addr;
  reg  [7:0]              nxt_wdata;
  reg                     nxt_taken;

  always @* begin
    nxt_phase = phase_ff + 2'h1;
    nxt_pc    = pc_ff;
    nxt_ir    = ir_ff;
    nxt_valid = valid_ff;
    nxt_flush = flush_ff;
    nxt_addr  = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_taken = 1'b0;
    case (phase_ff)
      `BBSD_Q1: begin
        // a flush cycle swallows the slot after a taken jump
        if (flush_ff) begin
          nxt_valid = 1'b0;
          nxt_flush = 1'b0;
        end else begin
          nxt_ir    = instr_word_in;
          nxt_valid = 1'b1;
          nxt_pc    = pc_ff + `BBSD_PC_STEP;
          nxt_addr  = bbsd_reg_addr(instr_word_in, bank_select_register_in,
                                    ext_set_enable_in, index_base_in);
        end
      end

      `BBSD_Q2: begin
        // read strobe is up this quarter; data settles by the next edge
        nxt_wdata = wdata_ff;
      end

      `BBSD_Q3: begin
        // merge taken late so a slow memory has the whole quarter
        nxt_wdata = merged;
      end

      `BBSD_Q4: begin
        if (take) begin
          nxt_pc    = target;
          nxt_flush = 1'b1;
          nxt_taken = 1'b1;
        end
      end

      default: begin
        nxt_phase = `BBSD_Q1;
      end
    endcase
  end

  // ==========================================================
  // registers
  // one flop per field; reset values are all constants
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      phase_ff <= `BBSD_Q1;
      pc_ff    <= `BBSD_PC_RST;
      ir_ff    <= 16'h0000;
      valid_ff <= 1'b0;
      flush_ff <= 1'b0;
      addr_ff  <= 12'h000;
      wdata_ff <= 8'h00;
      taken_ff <= 1'b0;
    end else begin
      phase_ff <= nxt_phase;
      pc_ff    <= nxt_pc;
      ir_ff    <= nxt_ir;
      valid_ff <= nxt_valid;
      flush_ff <= nxt_flush;
      addr_ff  <= nxt_addr;
      wdata_ff <= nxt_wdata;
      taken_ff <= nxt_taken;
    end
  end

  // ==========================================================
  // outputs
  // strobes are decoded from flops only, no input reaches them
  // status writes stay tied low: none of these touch a flag
  assign program_counter_out = pc_ff;
  assign mem_addr_out        = addr_ff;
  assign mem_rd_out          = valid_ff && is_bset && (phase_ff == `BBSD_Q2);
  assign mem_wr_out          = valid_ff && is_bset && (phase_ff == `BBSD_Q4);
  assign mem_wdata_out       = wdata_ff;
  assign status_we_out       = 1'b0;
  assign quarter_out         = phase_ff;
  assign branch_taken_out    = taken_ff;
endmodule // bbsd_decoder

// file: tb/bbsd_checker.sv
/* port checker for bbsd_decoder.
 assumes one clock and four quarters per cycle. */
`timescale 1ns/1ps
module bbsd_checker (
  input wire        sys_clk_in, rst_in, mem_rd_out, mem_wr_out,
  input wire        status_we_out, branch_taken_out,
  input wire [1:0]  quarter_out,
  input wire [7:0]  mem_rdata_in, mem_wdata_out,
  input wire [20:0] program_counter_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // ========
  // relations
  a_flags_never: assert property (!status_we_out)
    else $error("flags written");
  a_rd_then_wr: assert property (mem_rd_out |-> quarter_out == 2'h1 ##2 mem_wr_out)
    else $error("read slot");
  a_wr_phase: assert property (mem_wr_out |-> quarter_out == 2'h3)
    else $error("write slot");
  a_wr_merge: assert property (mem_wr_out |->
    (mem_wdata_out | $past(mem_rdata_in)) == mem_wdata_out &&
    $countones(mem_wdata_out ^ $past(mem_rdata_in)) < 2)
    else $error("bad merge");
  a_quarter_step: assert property (!$past(rst_in) |->
    quarter_out == $past(quarter_out) + 2'h1) else $error("quarter skip");
  a_taken_phase: assert property (branch_taken_out |->
    quarter_out == 2'h0 && !$past(branch_taken_out)) else $error("pulse");
  a_flush_hold: assert property (branch_taken_out |=> $stable(program_counter_out) [*4])
    else $error("no flush");
  a_pc_step: assert property (quarter_out == 2'h1 && !$past(branch_taken_out) |->
    program_counter_out == $past(program_counter_out) + 21'h2) else $error("pc step");
  c_write: cover property (mem_wr_out);
  c_taken: cover property (branch_taken_out);
  c_fetch: cover property (quarter_out == 2'h1);
endmodule // bbsd_checker
bind bbsd_decoder bbsd_checker u_chk (.*);

// file: tb/testbench.sv
/* self-checking bench for bbsd_decoder.
 assumes the design's defs header is on the include path. */
`timescale 1ns/1ps
module testbench;
  reg         sys_clk_in = 1'b0, rst_in = 1'b1;
  reg  [15:0] instr_word_in = 16'h0, w;
  reg  [31:0] r = 32'h0, rn;
  reg  [20:0] exp_pc = 21'h0, offs, seen, exp;
  reg  [11:0] ea;
  reg         taken;
  reg  [20:0] exp_q[$];
  wire [20:0] pc_seen;
  wire [11:0] addr_seen;
  wire [7:0]  wdata_seen;
  wire [1:0]  quarter;
  wire        wr_seen, taken_seen;
  integer     errors = 0, total_checks = 0, seed = 37796, i, kind;
  always #4 sys_clk_in = ~sys_clk_in;
  bbsd_decoder u_dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .instr_word_in(instr_word_in),
    .program_counter_out(pc_seen), .overflow_flag_in(r[0]), .zero_flag_in(r[1]),
    .bank_select_register_in(r[7:4]), .ext_set_enable_in(r[2]), .index_base_in(r[27:16]),
    .mem_addr_out(addr_seen), .mem_rd_out(), .mem_rdata_in(r[15:8]), .mem_wr_out(wr_seen),
    .mem_wdata_out(wdata_seen), .status_we_out(), .quarter_out(quarter),
    .branch_taken_out(taken_seen));
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  // ========
  // monitor: fetch address or written byte
  always @(negedge sys_clk_in)
    if (!rst_in && (wr_seen === 1'b1 || (quarter === 2'h0 && taken_seen === 1'b0))) begin
      seen = (wr_seen === 1'b1) ? {1'b0, addr_seen, wdata_seen} : pc_seen;
      exp = (exp_q.size() > 0) ? exp_q.pop_front() : ~seen;
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("mismatch result expected %h seen %h", exp, seen);
      end
    end
  initial begin
    #20000;
    errors = errors + 1;
    give_verdict;
  end
  // ========
  // driver: random mix of all four kinds plus no-ops
  initial begin
    repeat (16) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    for (i = 0; i < 60; i = i + 1) begin
      kind = $unsigned($random(seed)) % 5;
      w = $random(seed);
      case (kind)
        0: w[15:8] = 8'he5;
        1: w[15:8] = 8'he1;
        2: w[15:11] = 5'h1a;
        3: w[15:12] = 4'h8;
        default: w = 16'h0000;
      endcase
      rn = $random(seed);
      instr_word_in <= w;
      r <= rn;
      offs = (kind == 2) ? {{9{w[10]}}, w[10:0], 1'b0} : {{12{w[7]}}, w[7:0], 1'b0};
      taken = kind == 2 || (kind == 0 && !rn[0]) || (kind == 1 && !rn[1]);
      ea = w[8] ? {rn[7:4], w[7:0]} : (w[7:0] > 8'h5f) ? {4'hf, w[7:0]} :
        rn[2] ? rn[27:16] + w[7:0] : {4'h0, w[7:0]};
      exp_q.push_back(exp_pc);
      if (kind == 3) exp_q.push_back({1'b0, ea, rn[15:8] | (8'h1 << w[11:9])});
      exp_pc = exp_pc + 21'h2 + (taken ? offs : 21'h0);
      do @(negedge sys_clk_in); while (quarter !== 2'h0 || taken_seen !== 1'b0);
      repeat (4) @(posedge sys_clk_in);
    end
    $display("random mix done");
    give_verdict;
  end
endmodule // testbench
